// [verification/emb_embedder_test.sv]
// testbench: register access and framed pixel traffic through the embedder
module emb_embedder_test
  import emb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  // ************************************************************
  // signals
  // ************************************************************
  logic             mclk, rst, wb_cyc, wb_stb, wb_we, wb_ack, s_valid, s_ready;
  logic             m_valid, m_ready, m_valid2;
  logic [ADR_W-1:0] wb_adr;
  logic [3:0]       wb_sel;
  logic [31:0]      wb_dat_w, wb_dat_r, rd, nframes;
  emb_beat_t        s_beat, m_beat, m_beat2;
  emb_stat_t        stat;
  logic [8:0]       en;
  emb_beat_t        out_q[$], out2_q[$];
  emb_beat_t        exp_q[$], exp2_q[$];
  logic [7:0]       md[$], md2[$];
  int               fails, n_tests;

  emb_embedder #(.COLOR(1'b1), .FIFO_DEPTH(8)) u_dut (
    .mclk(mclk), .rst(rst), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat_w), .wb_dat_o(wb_dat_r),
    .wb_ack_o(wb_ack), .s_valid(s_valid), .s_beat(s_beat), .s_ready(s_ready),
    .stat(stat), .m_valid(m_valid), .m_beat(m_beat), .m_ready(m_ready));

  emb_src_model u_src (.mclk(mclk), .s_valid(s_valid), .s_beat(s_beat), .s_ready(s_ready));

  // monochrome twin on the same traffic: white balance must never appear
  emb_embedder #(.COLOR(1'b0), .FIFO_DEPTH(8)) u_mono (
    .mclk(mclk), .rst(rst), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat_w), .wb_dat_o(),
    .wb_ack_o(), .s_valid(s_valid), .s_beat(s_beat), .s_ready(),
    .stat(stat), .m_valid(m_valid2), .m_beat(m_beat2), .m_ready(m_ready));

  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  always @(posedge mclk)
  begin
    if (m_valid === 1'b1 && m_ready === 1'b1)
      out_q.push_back(m_beat);
    if (m_valid2 === 1'b1 && m_ready === 1'b1)
      out2_q.push_back(m_beat2);
  end

  // ************************************************************
  // tasks
  // ************************************************************
  task automatic report_and_stop();
    $display("fails %0d n_tests %0d", fails, n_tests);
    if (fails == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk32(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_beat(input string what, input int i, input emb_beat_t exp,
                          input emb_beat_t got);
    n_tests++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD %s %0d expected %h seen %h", what, i, exp, got);
    end
  endtask

  // classic cycle: held until ack is sampled, then one idle cycle
  task automatic wb_xfer(input logic we, input logic [3:0] adr, input logic [31:0] d);
    wb_cyc   <= 1'b1;
    wb_stb   <= 1'b1;
    wb_we    <= we;
    wb_adr   <= adr;
    wb_sel   <= 4'hf;
    wb_dat_w <= d;
    do @(posedge mclk); while (wb_ack !== 1'b1);
    rd = wb_dat_r;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we  <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic rd_chk(input string what, input logic [3:0] adr, input logic [31:0] exp);
    wb_xfer(1'b0, adr, 32'h0);
    chk32(what, exp, rd);
  endtask

  task automatic set_en(input logic [3:0] f, input logic v);
    wb_xfer(1'b1, ADR_SEL, {28'h0, f});
    wb_xfer(1'b1, ADR_EMBED, {31'h0, v});
    en[f] = v;
  endtask

  function automatic void add(input logic [63:0] v, input int n, input bit colour_only = 1'b0);
    for (int i = n - 1; i >= 0; i--)
    begin
      md.push_back(v[8*i +: 8]);
      if (!colour_only)
        md2.push_back(v[8*i +: 8]);
    end
  endfunction

  // ************************************************************
  // frame traffic and expectations
  // ************************************************************
  task automatic send(input int lines, input int len, input logic [7:0] base, input bit sof);
    emb_beat_t b;
    emb_beat_t b2;
    int        n;
    n = 0;
    md.delete();
    md2.delete();
    if (sof)
    begin
      if (en[F_TS])   add({32'h0, stat.ts}, 4);
      if (en[F_GAIN]) add({54'h0, stat.gain}, 4);
      if (en[F_EXPO]) add({32'h0, stat.expo}, 4);
      if (en[F_BRT])  add({52'h0, stat.brt}, 4);
      if (en[F_WB])   add({4'h0, stat.wb_r, 4'h0, stat.wb_g, 4'h0, stat.wb_b, 16'h0}, 8, 1'b1);
      if (en[F_FRM])  add({32'h0, nframes}, 4);
      if (en[F_TRIG]) add({32'h0, stat.trig}, 4);
      if (en[F_LINE]) add({32'h0, stat.line_in, stat.line_out, 16'h0}, 4);
      if (en[F_ROI])  add({stat.roi_col, stat.roi_row, stat.roi_len, stat.roi_wid}, 8);
    end
    for (int l = 0; l < lines; l++)
      for (int c = 0; c < len; c++)
      begin
        b.data = 8'(base + n);
        b.sof  = sof && n == 0;
        b.eol  = c == len - 1;
        u_src.push(b);
        if (n == 0)
          stat <= ~stat;
        b2 = b;
        if (n < md2.size())
          b2.data = md2[n];
        exp2_q.push_back(b2);
        if (n < md.size())
          b.data = md[n];
        exp_q.push_back(b);
        n++;
      end
    u_src.idle();
    if (sof)
      nframes++;
    @(posedge mclk);
  endtask

  task automatic check_out();
    int k;
    k = 0;
    while ((out_q.size() < exp_q.size() || out2_q.size() < exp2_q.size()) && k < 2000)
    begin
      @(posedge mclk);
      k++;
    end
    repeat (4) @(posedge mclk);
    chk32("beat count", exp_q.size(), out_q.size());
    foreach (exp_q[i])
      if (i < out_q.size())
        chk_beat("beat", i, exp_q[i], out_q[i]);
    chk32("mono beat count", exp2_q.size(), out2_q.size());
    foreach (exp2_q[i])
      if (i < out2_q.size())
        chk_beat("mono beat", i, exp2_q[i], out2_q[i]);
    exp_q.delete();
    out_q.delete();
    exp2_q.delete();
    out2_q.delete();
  endtask

  // ************************************************************
  // main sequence
  // ************************************************************
  initial
  begin
    fails = 0;
    n_tests = 0;
    rst = 1'b1;
    {wb_cyc, wb_stb, wb_we, wb_adr, wb_sel, wb_dat_w} = '0;
    m_ready = 1'b1;
    en = 9'h0;
    nframes = 32'h0;
    stat = '0;
    stat.ts = 32'h11223344;
    stat.gain = 10'h2a5;
    stat.expo = 32'h00012345;
    stat.brt = 12'habc;
    stat.wb_r = 12'h123;
    stat.wb_g = 12'h456;
    stat.wb_b = 12'h789;
    stat.trig = 32'hcafe0001;
    stat.line_in = 8'h5a;
    stat.line_out = 8'ha5;
    stat.roi_col = 16'h0010;
    stat.roi_row = 16'h0020;
    stat.roi_len = 16'h0280;
    stat.roi_wid = 16'h01e0;
    repeat (16) @(posedge mclk);
    chk32("s_ready in reset", 32'h0, {31'h0, s_ready});
    rst <= 1'b0;
    @(posedge mclk);
    rd_chk("sel reset", ADR_SEL, 32'h0);
    rd_chk("embed reset", ADR_EMBED, 32'h0);
    rd_chk("mask reset", ADR_MASK, 32'h0);
    rd_chk("frames reset", ADR_FRAMES, 32'h0);
    for (int f = 0; f < 9; f++)
      set_en(4'(f), 1'b1);
    rd_chk("mask all", ADR_MASK, 32'h1ff);
    wb_xfer(1'b1, ADR_SEL, 32'h9);
    wb_xfer(1'b1, ADR_EMBED, 32'h1);
    rd_chk("embed bad sel", ADR_EMBED, 32'h0);
    wb_xfer(1'b1, ADR_MASK, 32'h0);
    rd_chk("mask read only", ADR_MASK, 32'h1ff);
    // bytes ahead of the first frame start must pass untouched
    send(1, 3, 8'ha0, 1'b0);
    send(3, 20, 8'h00, 1'b1);
    check_out();
    set_en(F_TS, 1'b0);
    set_en(F_BRT, 1'b0);
    set_en(F_WB, 1'b0);
    set_en(F_ROI, 1'b0);
    rd_chk("embed cleared", ADR_EMBED, 32'h0);
    rd_chk("mask part", ADR_MASK, 32'h0e6);
    fork
      begin
        m_ready <= 1'b0;
        repeat (30) @(posedge mclk);
        chk32("s_ready full", 32'h0, {31'h0, s_ready});
        chk32("m_valid stalled", 32'h1, {31'h0, m_valid});
        m_ready <= 1'b1;
      end
      send(2, 12, 8'h40, 1'b1);
    join
    check_out();
    chk32("m_valid drained", 32'h0, {31'h0, m_valid});
    for (int f = 0; f < 9; f++)
      set_en(4'(f), 1'b0);
    send(1, 10, 8'h80, 1'b1);
    check_out();
    rd_chk("frames", ADR_FRAMES, 32'h3);
    report_and_stop();
  end

  initial
  begin
    #1000000;
    fails++;
    report_and_stop();
  end
endmodule // emb_embedder_test

// [verification/emb_src_model.sv]
// partner model: camera pipeline feeding pixel bytes to the embedder
module emb_src_model
  import emb_pkg::*;
(
  // clock
  input  wire logic      mclk,
  // pixel stream towards the embedder
  output      logic      s_valid,
  output      emb_beat_t s_beat,
  input  wire logic      s_ready
);
  timeunit 1ns;
  timeprecision 1ns;

  initial
  begin
    s_valid = 1'b0;
    s_beat  = '0;
  end

  // call just after an edge; returns at the edge that took the byte
  task automatic push(input emb_beat_t b);
    s_valid <= 1'b1;
    s_beat  <= b;
    do @(posedge mclk); while (s_ready !== 1'b1);
  endtask

  // a released bus shows the inverse, so a stale byte never looks valid
  task automatic idle();
    s_valid <= 1'b0;
    s_beat  <= ~s_beat;
  endtask
endmodule // emb_src_model

// [verilog/emb_embedder.sv]
// module: per-frame metadata embedder, top level
// Function
// [RULE1] only enabled fields, in fixed order
// [RULE2] selector picks field, enable adds it
// [RULE3] timestamp: 4 bytes, always first
// [RULE4] gain: 4 bytes, 0..1023, zero-filled
// [RULE5] exposure: 4 bytes, microseconds
// [RULE6] brightness: 4 bytes, 0..4095, zero-filled
// [RULE7] white balance: R,G,B 2 bytes each
// [RULE8] white balance only on colour variants
// [RULE9] frame and trigger counts: 32-bit unsigned
// [RULE10] line state: inputs, outputs, two reserved
// [RULE11] region: column, row, length, width
// [RULE12] overwrite from frame start, spill onward
// [RULE13] msb first, reserved bytes zero
// [RULE14] all values sampled at frame start
//
// The register offsets and the Wishbone interface to the registers were chosen for this implementation.
module emb_embedder
  import emb_pkg::*;
#(
  parameter bit COLOR      = 1'b1,
  parameter int FIFO_DEPTH = 8
) (
  // clock and reset
  input  wire logic                  mclk,
  input  wire logic                  rst,
  // wishbone slave
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [emb_pkg::ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]            wb_sel_i,
  input  wire logic [31:0]           wb_dat_i,
  output      logic [31:0]           wb_dat_o,
  output      logic                  wb_ack_o,
  // pixel stream in
  input  wire logic                  s_valid,
  input  wire emb_pkg::emb_beat_t    s_beat,
  output      logic                  s_ready,
  // live status values
  input  wire emb_pkg::emb_stat_t    stat,
  // pixel stream out
  output      logic                  m_valid,
  output      emb_pkg::emb_beat_t    m_beat,
  input  wire logic                  m_ready
);
  import emb_pkg::*;

  // ************************************************************
  // state
  // ************************************************************
  emb_state_t  st_ff;
  emb_snap_t   snap_ff;
  logic [8:0]  en_ff;
  logic [3:0]  fld_ff;
  logic [3:0]  bcnt_ff;
  logic [31:0] frm_cnt_ff;
  logic [8:0]  cfg_en;
  emb_beat_t   wr_beat;

  // ************************************************************
  // register file
  // ************************************************************
  emb_wb_regs u_regs (
    .mclk     (mclk),
    .rst      (rst),
    .wb_cyc_i (wb_cyc_i),
    .wb_stb_i (wb_stb_i),
    .wb_we_i  (wb_we_i),
    .wb_adr_i (wb_adr_i),
    .wb_sel_i (wb_sel_i),
    .wb_dat_i (wb_dat_i),
    .wb_dat_o (wb_dat_o),
    .wb_ack_o (wb_ack_o),
    .frames   (frm_cnt_ff),
    .en_mask  (cfg_en)
  );

  // ************************************************************
  // field selection
  // ************************************************************
  // monochrome parts cannot carry white balance, whatever software sets
  wire [8:0]   en_live   = COLOR ? cfg_en : (cfg_en & ~WB_MASK);          // [RULE8]
  wire         fire      = s_valid && s_ready;
  wire         is_sof    = s_beat.sof;
  emb_snap_t   live_snap;
  assign live_snap.frame = frm_cnt_ff;
  assign live_snap.st    = stat;

  // the frame's first beat already carries metadata, so it uses live values
  emb_snap_t   cur_src;
  assign cur_src = is_sof ? live_snap : snap_ff;                          // [RULE14]
  wire [8:0]   cur_en    = is_sof ? en_live : en_ff;
  wire [3:0]   cur_fld   = is_sof ? emb_first_from(en_live, F_TS) : fld_ff; // [RULE1] [RULE3]
  wire [3:0]   cur_b     = is_sof ? 4'h0 : bcnt_ff;
  wire         in_meta   = cur_fld != F_NONE && (is_sof || st_ff == ST_EMBED); // [RULE12]
  wire [3:0]   cur_len   = emb_fld_len(cur_fld);
  wire         last_b    = cur_b == 4'(cur_len - 4'h1);
  wire [3:0]   nxt_fld   = last_b ? emb_first_from(cur_en, 4'(cur_fld + 4'h1)) : cur_fld; // [RULE1]
  wire [3:0]   nxt_b     = last_b ? 4'h0 : 4'(cur_b + 4'h1);

  // ************************************************************
  // byte picking
  // ************************************************************
  wire [63:0]  cur_word  = emb_field_word(cur_src, cur_fld);
  wire [3:0]   sh_bytes  = 4'(cur_len - 4'h1 - cur_b);
  wire [63:0]  shifted   = cur_word >> {sh_bytes[2:0], 3'b000};           // [RULE13]
  wire [7:0]   meta_byte = shifted[7:0];

  assign wr_beat.data = in_meta ? meta_byte : s_beat.data;                // [RULE12]
  assign wr_beat.sof  = s_beat.sof;
  assign wr_beat.eol  = s_beat.eol;

  // ************************************************************
  // sequencing
  // ************************************************************
  emb_state_t  nxt_st;
  // a frame start restarts the sequence from any state, even mid-metadata
  always_comb
  begin
    nxt_st = st_ff;
    if (fire && is_sof)
      nxt_st = (in_meta && nxt_fld != F_NONE) ? ST_EMBED : ST_PASS;
    else if (fire)
    begin
      unique case (st_ff)
        ST_WAIT:  nxt_st = ST_WAIT;
        ST_EMBED: nxt_st = (nxt_fld == F_NONE) ? ST_PASS : ST_EMBED;
        ST_PASS:  nxt_st = ST_PASS;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      st_ff      <= ST_WAIT;
      snap_ff    <= '0;
      en_ff      <= MASK_RST;
      fld_ff     <= F_NONE;
      bcnt_ff    <= 4'h0;
      frm_cnt_ff <= 32'h0;
    end
    else
    begin
      st_ff <= nxt_st;
      if (fire && is_sof)
      begin
        snap_ff    <= live_snap;                                          // [RULE14]
        en_ff      <= en_live;                                            // [RULE14]
        frm_cnt_ff <= frm_cnt_ff + 32'h1;                                 // [RULE9]
      end
      if (fire && in_meta)
      begin
        fld_ff  <= nxt_fld;
        bcnt_ff <= nxt_b;
      end
    end
  end

  // ************************************************************
  // output buffer
  // ************************************************************
  // a stalled consumer fills the buffer and then holds off the pipeline
  emb_fifo #(
    .W     ($bits(emb_beat_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .mclk      (mclk),
    .rst       (rst),
    .in_valid  (s_valid),
    .in_data   (wr_beat),
    .in_ready  (s_ready),
    .out_valid (m_valid),
    .out_data  (m_beat),
    .out_ready (m_ready)
  );

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  a_ts_first_byte: assert property (
    fire && is_sof && en_live[0] |-> wr_beat.data == stat.ts[31:24]) // [RULE3]
    else $error("timestamp is not the first byte of the frame");

  a_field_order: assert property (
    fire && in_meta && last_b && nxt_fld != F_NONE |=> fld_ff > $past(cur_fld)) // [RULE1]
    else $error("metadata fields out of order");

  a_gain_high_zero: assert property (
    fire && in_meta && cur_fld == F_GAIN && cur_b == 4'h2 |-> wr_beat.data[7:2] == 6'h0) // [RULE4]
    else $error("gain upper bits not zero");

  a_brt_high_zero: assert property (
    fire && in_meta && cur_fld == F_BRT && cur_b == 4'h2 |-> wr_beat.data[7:4] == 4'h0) // [RULE6]
    else $error("brightness upper bits not zero");

  a_expo_msb_first: assert property ( // [RULE5]
    fire && in_meta && cur_fld == F_EXPO && cur_b == 4'h0
      |-> wr_beat.data == (is_sof ? stat.expo[31:24] : snap_ff.st.expo[31:24]))
    else $error("exposure not sent msb first");

  a_wb_mono_off: assert property (
    !COLOR |-> !(fire && in_meta && cur_fld == F_WB)) // [RULE8]
    else $error("white balance embedded on a monochrome part");

  a_line_resv_zero: assert property (
    fire && in_meta && cur_fld == F_LINE && cur_b[1] |-> wr_beat.data == 8'h00) // [RULE10]
    else $error("reserved line state byte not zero");

  a_snap_held: assert property (
    !(fire && is_sof) |=> $stable(snap_ff) && $stable(en_ff)) // [RULE14]
    else $error("snapshot changed inside a frame");

  a_frame_count: assert property (
    fire && is_sof |=> frm_cnt_ff == $past(frm_cnt_ff) + 32'h1) // [RULE9]
    else $error("frame counter did not advance");

  a_roi_eight: assert property (
    fire && in_meta && cur_fld == F_ROI && cur_b == 4'h7 |-> last_b) // [RULE11]
    else $error("region field length wrong");

  a_pass_through: assert property (
    fire && !in_meta |-> wr_beat.data == s_beat.data) // [RULE12]
    else $error("image data altered outside metadata");

  // checker helper: metadata bytes since the frame start, bounded by the field table
  localparam logic [7:0] META_MAX = 8'(7 * LEN_SHORT + 2 * LEN_LONG);
  logic [7:0]  mcnt_ff;

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      mcnt_ff <= 8'h0;
    else if (fire && is_sof)
      mcnt_ff <= {7'h0, in_meta};
    else if (fire && in_meta)
      mcnt_ff <= 8'(mcnt_ff + 8'h1);
  end

  a_meta_bound: assert property ( // [RULE1]
    mcnt_ff != 8'h0
      |-> mcnt_ff <= (COLOR ? META_MAX : 8'(META_MAX - LEN_LONG)))
    else $error("more metadata bytes than the field table allows");

  a_byte_in_field: assert property ( // [RULE13]
    fire && in_meta
      |-> cur_b < cur_len)
    else $error("byte index beyond field length");

  a_gain_pad_zero: assert property ( // [RULE4]
    fire && in_meta && cur_fld == F_GAIN && !cur_b[1]
      |-> wr_beat.data == 8'h00)
    else $error("gain pad byte not zero");

  a_brt_pad_zero: assert property ( // [RULE6]
    fire && in_meta && cur_fld == F_BRT && !cur_b[1]
      |-> wr_beat.data == 8'h00)
    else $error("brightness pad byte not zero");

  a_wb_even_nibble: assert property ( // [RULE7]
    fire && in_meta && cur_fld == F_WB && !cur_b[0]
      |-> wr_beat.data[7:4] == 4'h0)
    else $error("white balance upper bits not zero");

  a_wb_pad_zero: assert property ( // [RULE7]
    fire && in_meta && cur_fld == F_WB && cur_b[2:1] == 2'b11
      |-> wr_beat.data == 8'h00)
    else $error("white balance tail not zero");

  a_trig_msb_first: assert property ( // [RULE9]
    fire && in_meta && cur_fld == F_TRIG && cur_b == 4'h0
      |-> wr_beat.data == (is_sof ? stat.trig[31:24] : snap_ff.st.trig[31:24]))
    else $error("trigger count not sent msb first");

  a_frame_lsb_last: assert property ( // [RULE9]
    fire && in_meta && cur_fld == F_FRM && cur_b == 4'h3
      |-> wr_beat.data == (is_sof ? frm_cnt_ff[7:0] : snap_ff.frame[7:0]))
    else $error("frame counter low byte misplaced");

  a_line_in_first: assert property ( // [RULE10]
    fire && in_meta && cur_fld == F_LINE && cur_b == 4'h0
      |-> wr_beat.data == (is_sof ? stat.line_in : snap_ff.st.line_in))
    else $error("input line byte misplaced");

  a_roi_col_first: assert property ( // [RULE11]
    fire && in_meta && cur_fld == F_ROI && cur_b == 4'h0
      |-> wr_beat.data == (is_sof ? stat.roi_col[15:8] : snap_ff.st.roi_col[15:8]))
    else $error("region column not first");

  c_all_fields: cover property (fire && is_sof && en_live == 9'h1ff);
  c_spill_line: cover property (fire && in_meta && s_beat.eol ##1 fire && in_meta);
  c_back_press: cover property (s_valid && !s_ready);
  c_roi_done:   cover property (fire && in_meta && cur_fld == F_ROI && last_b);
  c_no_fields:  cover property (fire && is_sof && en_live == 9'h000);
endmodule // emb_embedder

// [verilog/emb_fifo.sv]
// module: output fifo with a registered head
module emb_fifo #(
  parameter int W     = 10,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic         mclk,
  input  wire logic         rst,
  // fill side
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output      logic         in_ready,
  // drain side
  output      logic         out_valid,
  output      logic [W-1:0] out_data,
  input  wire logic         out_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wptr_ff;
  logic [AW-1:0] rptr_ff;
  logic [AW:0]   cnt_ff;
  logic          rdy_ff;
  logic          ovalid_ff;
  logic [W-1:0]  odata_ff;

  // ready is registered, so it looks one entry ahead to stay honest
  wire           wr      = in_valid && rdy_ff;
  wire           rd      = (!ovalid_ff || out_ready) && cnt_ff != '0;
  wire [AW:0]    nxt_cnt = (AW+1)'(cnt_ff + (AW+1)'(wr) - (AW+1)'(rd));

  always_ff @(posedge mclk)
  begin
    if (wr)
      mem[wptr_ff] <= in_data;
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      wptr_ff   <= '0;
      rptr_ff   <= '0;
      cnt_ff    <= '0;
      rdy_ff    <= 1'b0;
      ovalid_ff <= 1'b0;
      odata_ff  <= '0;
    end
    else
    begin
      wptr_ff <= wr ? AW'(wptr_ff + 1'b1) : wptr_ff;
      rptr_ff <= rd ? AW'(rptr_ff + 1'b1) : rptr_ff;
      cnt_ff  <= nxt_cnt;
      rdy_ff  <= nxt_cnt < (AW+1)'(DEPTH);
      if (rd)
      begin
        ovalid_ff <= 1'b1;
        odata_ff  <= mem[rptr_ff];
      end
      else if (out_ready)
        ovalid_ff <= 1'b0;
    end
  end

  assign in_ready  = rdy_ff;
  assign out_valid = ovalid_ff;
  assign out_data  = odata_ff;
endmodule // emb_fifo

// [verilog/emb_pkg.sv]
// package: field codes, register map, carriers and field helpers of the embedder
package emb_pkg;

  // ************************************************************
  // field codes, in emission order
  // ************************************************************
  localparam logic [3:0] F_TS   = 4'h0;
  localparam logic [3:0] F_GAIN = 4'h1;
  localparam logic [3:0] F_EXPO = 4'h2;
  localparam logic [3:0] F_BRT  = 4'h3;
  localparam logic [3:0] F_WB   = 4'h4;
  localparam logic [3:0] F_FRM  = 4'h5;
  localparam logic [3:0] F_TRIG = 4'h6;
  localparam logic [3:0] F_LINE = 4'h7;
  localparam logic [3:0] F_ROI  = 4'h8;
  localparam logic [3:0] F_NONE = 4'h9;
  localparam int         NFIELD = 9;
  localparam logic [3:0] LEN_SHORT = 4'h4;
  localparam logic [3:0] LEN_LONG  = 4'h8;

  // ************************************************************
  // register map and reset values
  // ************************************************************
  localparam int         ADR_W      = 4;
  localparam logic [3:0] ADR_SEL    = 4'h0;
  localparam logic [3:0] ADR_EMBED  = 4'h4;
  localparam logic [3:0] ADR_MASK   = 4'h8;
  localparam logic [3:0] ADR_FRAMES = 4'hc;
  localparam logic [3:0] SEL_RST    = 4'h0;
  localparam logic [8:0] MASK_RST   = 9'h000;
  localparam logic [8:0] WB_MASK    = 9'h010;

  // ************************************************************
  // carriers
  // ************************************************************
  typedef struct packed {
    logic [7:0] data;
    logic       sof;
    logic       eol;
  } emb_beat_t;

  typedef struct packed {
    logic [31:0] ts;
    logic [9:0]  gain;
    logic [31:0] expo;
    logic [11:0] brt;
    logic [11:0] wb_r;
    logic [11:0] wb_g;
    logic [11:0] wb_b;
    logic [31:0] trig;
    logic [7:0]  line_in;
    logic [7:0]  line_out;
    logic [15:0] roi_col;
    logic [15:0] roi_row;
    logic [15:0] roi_len;
    logic [15:0] roi_wid;
  } emb_stat_t;

  typedef struct packed {
    logic [31:0] frame;
    emb_stat_t   st;
  } emb_snap_t;

  typedef enum logic [2:0] {
    ST_WAIT  = 3'b001,
    ST_EMBED = 3'b010,
    ST_PASS  = 3'b100
  } emb_state_t;

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic [3:0] emb_fld_len(input logic [3:0] f);
    return (f == F_WB || f == F_ROI) ? LEN_LONG : LEN_SHORT;
  endfunction

  // first enabled field at or after start, F_NONE when none is left
  function automatic logic [3:0] emb_first_from(input logic [8:0] en,
                                                input logic [3:0] start);
    logic [3:0] r;
    r = F_NONE;
    for (int i = NFIELD - 1; i >= 0; i--)
    begin
      if (4'(i) >= start && en[i])
        r = 4'(i);
    end
    return r;
  endfunction

  // field laid out right-aligned, most significant byte first on the wire
  function automatic logic [63:0] emb_field_word(input emb_snap_t s, input logic [3:0] f);
    logic [63:0] w;
    w = 64'h0;
    case (f)
      F_TS:    w = {32'h0, s.st.ts};
      F_GAIN:  w = {54'h0, s.st.gain};                            // [RULE4]
      F_EXPO:  w = {32'h0, s.st.expo};                            // [RULE5]
      F_BRT:   w = {52'h0, s.st.brt};                             // [RULE6]
      F_WB:    w = {4'h0, s.st.wb_r, 4'h0, s.st.wb_g, 4'h0, s.st.wb_b, 16'h0}; // [RULE7]
      F_FRM:   w = {32'h0, s.frame};                              // [RULE9]
      F_TRIG:  w = {32'h0, s.st.trig};                            // [RULE9]
      F_LINE:  w = {32'h0, s.st.line_in, s.st.line_out, 16'h0};   // [RULE10]
      F_ROI:   w = {s.st.roi_col, s.st.roi_row, s.st.roi_len, s.st.roi_wid}; // [RULE11]
      default: w = 64'h0;
    endcase
    return w;
  endfunction

endpackage

// [verilog/emb_wb_regs.sv]
// module: wishbone register file of the embedder
module emb_wb_regs
  import emb_pkg::*;
(
  // clock and reset
  input  wire logic              mclk,
  input  wire logic              rst,
  // wishbone slave
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [ADR_W-1:0]  wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output      logic [31:0]       wb_dat_o,
  output      logic              wb_ack_o,
  // block side
  input  wire logic [31:0]       frames,
  output      logic [8:0]        en_mask
);
  logic        ack_ff;
  logic [31:0] dat_ff;
  logic [3:0]  sel_ff;
  logic [8:0]  mask_ff;

  wire         acc      = wb_cyc_i && wb_stb_i && !ack_ff;
  // a write lands on the edge where the master samples ack, request still held
  wire         wr_lo    = wb_cyc_i && wb_stb_i && ack_ff && wb_we_i && wb_sel_i[0];
  wire [15:0]  sel_wide = 16'h1 << sel_ff;
  wire [8:0]   sel_dec  = sel_wide[8:0];
  wire [8:0]   nxt_mask = wb_dat_i[0] ? (mask_ff | sel_dec) : (mask_ff & ~sel_dec);
  wire         sel_en   = |(mask_ff & sel_dec);
  wire [31:0]  nxt_dat  = wb_adr_i == ADR_SEL    ? {28'h0, sel_ff} :
                          wb_adr_i == ADR_EMBED  ? {31'h0, sel_en} :
                          wb_adr_i == ADR_MASK   ? {23'h0, mask_ff} :
                          wb_adr_i == ADR_FRAMES ? frames : 32'h0;

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      ack_ff  <= 1'b0;
      dat_ff  <= 32'h0;
      sel_ff  <= SEL_RST;
      mask_ff <= MASK_RST;
    end
    else
    begin
      ack_ff <= acc;
      dat_ff <= acc ? nxt_dat : 32'h0;
      if (wr_lo && wb_adr_i == ADR_SEL)
        sel_ff <= wb_dat_i[3:0];                                  // [RULE2]
      if (wr_lo && wb_adr_i == ADR_EMBED)
        mask_ff <= nxt_mask;                                      // [RULE2]
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = dat_ff;
  assign en_mask  = mask_ff;
endmodule // emb_wb_regs
